// file: bench/alarm_checker.sv
// Assertions on the alarm block ports
module alarm_checker (
    input logic       sys_clk,           // Clock
    input logic       resetn,            // Reset, low
    input logic       reg_rd,            // Read strobe
    input logic [7:0] reg_addr,          // Offset
    input logic [7:0] reg_rdata,         // Read data
    input logic       sec_tick,          // Second pulse
    input logic       alarm1_irq_enable, // Enable 1
    input logic       alarm2_irq_enable, // Enable 2
    input logic       flag_clr_wr,       // Clear strobe
    input logic [1:0] flag_clr_data,     // Clear bits
    input logic       alarm1_match_flag, // Flag 1
    input logic       alarm2_match_flag, // Flag 2
    input logic       alarm_irq          // Interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    // Clears only count without a tick, since a set wins
    wire c1 = flag_clr_wr & flag_clr_data[0];
    wire c2 = flag_clr_wr & flag_clr_data[1];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    irq_level_a: assert property (alarm_irq == (alarm1_match_flag &
        alarm1_irq_enable | alarm2_match_flag & alarm2_irq_enable))
        else $error("irq mismatch");
    clr_one_a: assert property (c1 && !sec_tick |=> !alarm1_match_flag)
        else $error("flag 1 kept");
    clr_two_a: assert property (c2 && !sec_tick |=> !alarm2_match_flag)
        else $error("flag 2 kept");
    keep_one_a: assert property (alarm1_match_flag && !c1 |=>
        alarm1_match_flag) else $error("flag 1 lost");
    keep_two_a: assert property (alarm2_match_flag && !c2 |=>
        alarm2_match_flag) else $error("flag 2 lost");
    rise_one_a: assert property ($rose(alarm1_match_flag) |->
        $past(sec_tick)) else $error("flag 1 rose without tick");
    rise_two_a: assert property ($rose(alarm2_match_flag) |->
        $past(sec_tick)) else $error("flag 2 rose without tick");
    rd_unmapped_a: assert property (reg_rd && (reg_addr < 8'h47 ||
        reg_addr > 8'h4E) |=> reg_rdata == 8'h00) else $error("bad read");
    rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    cover property ($rose(alarm1_match_flag));
    cover property ($rose(alarm2_match_flag));
    cover property ($rose(alarm_irq));
endmodule // alarm_checker

// file: bench/host_model.sv
// Host side register master model
module host_model (
    input  logic       sys_clk,          // Clock
    output logic       reg_wr = 1'b0,    // Write strobe
    output logic       reg_rd = 1'b0,    // Read strobe
    output logic [7:0] reg_addr = 8'h00, // Offset
    output logic [7:0] reg_wdata = 8'h00, // Write data
    input  logic [7:0] reg_rdata         // Read data
);
    timeunit 1ns;
    timeprecision 1ps;
    // One byte per strobe, held a single cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // Data is taken once the registered answer has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask
endmodule // host_model

// file: bench/tb.sv
// Self-checking bench for the dual alarm block
`include "rtc_alarm_consts.vh"
`define CHK(g, e) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("wrong value at %0t: %h, expected %h", $time, g, e); \
    end \
end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk = 1'b0;
    logic       resetn = 1'b0;
    logic       sec_tick = 1'b0;
    logic       flag_clr_wr = 1'b0;
    logic [1:0] flag_clr_data = 2'h0;
    logic [1:0] en = 2'h0;
    logic [7:0] tv [5] = '{default: 8'h00};
    logic [7:0] r [8];
    logic [7:0] d;
    logic [1:0] ef;
    wire        reg_wr, reg_rd, alarm_irq;
    wire        alarm1_match_flag, alarm2_match_flag;
    wire  [7:0] reg_addr, reg_wdata, reg_rdata;
    int         seed = 96, err_count = 0, comparisons = 0, k;

    host_model i_host (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata);
    rtc_dual_alarm_match i_dut (.sys_clk, .resetn, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_rdata, .sec_tick, .time_sec(tv[0]),
        .time_min(tv[1]), .time_hr(tv[2]), .time_day(tv[3]),
        .time_date(tv[4]), .alarm1_irq_enable(en[0]),
        .alarm2_irq_enable(en[1]), .flag_clr_wr, .flag_clr_data,
        .alarm1_match_flag, .alarm2_match_flag, .alarm_irq);

    // Expected match of the alarm whose bytes start at r[b]
    function automatic logic hit(input int b);
        hit = (r[b][7] | r[b][6:0] == tv[0][6:0])
            & (r[b+1][7] | r[b+1][6:0] == tv[1][6:0])
            & (r[b+2][7] | r[b+2][6:0] == tv[2][6:0])
            & (r[b+3][7] | (r[b+3][6] ? r[b+3][3:0] == tv[3][3:0]
            : r[b+3][5:0] == tv[4][5:0]));
    endfunction

    task automatic final_report;
        $display("comparisons %0d, err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial forever #4 sys_clk = ~sys_clk;
    // Whole run is near 2500 cycles, so this only trips on a hang
    initial begin
        #100000;
        err_count++;
        final_report;
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        // Reset values, with an unmapped offset at either end
        for (int i = 0; i < 10; i++) begin
            i_host.rd(`ALARM_FIRST_OFS - 8'h01 + i[7:0], d);
            `CHK(d, 8'h00)
        end
        for (int n = 0; n < 60; n++) begin
            // First pass is all masks clear, alarm 1 in weekday mode and alarm 2 in date mode, exact time
            for (int i = 0; i < 8; i++) begin
                r[i] = 8'($random(seed));
                if (n == 0) r[i] = {1'b0, i == 3, r[i][5:0]};
                i_host.wr(`ALARM_FIRST_OFS + i[7:0], r[i]);
            end
            i_host.wr(`ALARM_LAST_OFS + 8'h01, 8'hFF);
            for (int i = 0; i < 8; i++) begin
                i_host.rd(`ALARM_FIRST_OFS + i[7:0], d);
                `CHK(d, r[i])
            end
            // Time copies alarm 1, one field nudged most of the time
            k = n == 0 ? 7 : {$random(seed)} % 8;
            @(posedge sys_clk);
            for (int i = 0; i < 5; i++) tv[i] <= r[i > 3 ? 3 : i] ^ (k == i);
            en <= 2'($random(seed));
            @(posedge sys_clk);
            sec_tick <= 1'b1;
            // Odd passes clear with the tick; the set must win
            flag_clr_wr <= n[0];
            flag_clr_data <= 2'h3;
            @(posedge sys_clk);
            sec_tick <= 1'b0;
            flag_clr_wr <= 1'b0;
            @(negedge sys_clk);
            ef = {hit(4), hit(0)};
            `CHK({alarm2_match_flag, alarm1_match_flag}, ef)
            `CHK(alarm_irq, |(ef & en))
            @(posedge sys_clk);
            flag_clr_wr <= 1'b1;
            flag_clr_data <= 2'($random(seed));
            @(posedge sys_clk);
            flag_clr_wr <= 1'b0;
            @(negedge sys_clk);
            ef = ef & ~flag_clr_data;
            `CHK({alarm2_match_flag, alarm1_match_flag}, ef)
            @(posedge sys_clk);
            flag_clr_wr <= 1'b1;
            flag_clr_data <= 2'h3;
            @(posedge sys_clk);
            flag_clr_wr <= 1'b0;
        end
        final_report;
    end
endmodule // tb

bind rtc_dual_alarm_match alarm_checker i_chk (.sys_clk, .resetn, .reg_rd,
    .reg_addr, .reg_rdata, .sec_tick, .alarm1_irq_enable, .alarm2_irq_enable,
    .flag_clr_wr, .flag_clr_data, .alarm1_match_flag, .alarm2_match_flag,
    .alarm_irq);

// file: design/alarm_compare.v
// Match logic for one alarm against the current time counters
`include "rtc_alarm_consts.vh"

module alarm_compare (
    input  wire [7:0] alm_sec,    // Alarm seconds register
    input  wire [7:0] alm_min,    // Alarm minutes register
    input  wire [7:0] alm_hr,     // Alarm hours register
    input  wire [7:0] alm_day,    // Alarm day-or-date register
    input  wire [7:0] time_sec,   // Current seconds, BCD
    input  wire [7:0] time_min,   // Current minutes, BCD
    input  wire [7:0] time_hr,    // Current hours, BCD with format bits
    input  wire [7:0] time_day,   // Current weekday, BCD 1..7
    input  wire [7:0] time_date,  // Current day of month, BCD
    output wire       match       // All unmasked fields equal
);

    wire sec_eq;
    wire min_eq;
    wire hr_eq;
    wire day_eq;

    // Seconds and minutes: units plus three tens bits
    assign sec_eq = (alm_sec[`TENS_MSB:`UNITS_LSB] ==
                     time_sec[`TENS_MSB:`UNITS_LSB]);        // R02
    assign min_eq = (alm_min[`TENS_MSB:`UNITS_LSB] ==
                     time_min[`TENS_MSB:`UNITS_LSB]);        // R03

    // Hours: format bit compared too, so 12h alarms never hit 24h time
    assign hr_eq = (alm_hr[`HR_TWELVE_SEL_BIT:`UNITS_LSB] ==
                    time_hr[`HR_TWELVE_SEL_BIT:`UNITS_LSB]); // R04 R05 R06

    // Day of week uses low nibble only; date uses tens and units
    assign day_eq = alm_day[`WEEKDAY_SEL_BIT] ?
        (alm_day[`UNITS_MSB:`UNITS_LSB] ==
         time_day[`UNITS_MSB:`UNITS_LSB]) :                  // R07 R08
        (alm_day[`DATE_TENS_MSB:`UNITS_LSB] ==
         time_date[`DATE_TENS_MSB:`UNITS_LSB]);              // R09 R10

    // A set mask bit removes its field from the comparison
    assign match = (alm_sec[`MASK_BIT] | sec_eq) &
                   (alm_min[`MASK_BIT] | min_eq) &
                   (alm_hr[`MASK_BIT]  | hr_eq)  &
                   (alm_day[`MASK_BIT] | day_eq);            // R14 R15

endmodule // alarm_compare

// file: design/rtc_dual_alarm_match.v
// Dual time-of-day alarm registers, once-per-second match and flags
//
// Summary of operation
// R01: Two alarms, each with own 8-bit registers
// R02: Seconds: units [3:0], tens [6:4], mask bit7
// R03: Minutes: units [3:0], tens [6:4], mask bit7
// R04: Hours: units [3:0], tens lsb bit4, mask bit7
// R05: Hours bit6 selects 12-hour or 24-hour
// R06: Hours bit5 is afternoon or tens msb
// R07: Day bit6 selects weekday or date; mask bit7
// R08: Weekday mode: low nibble is day 1..7
// R09: Date mode: low nibble is date units
// R10: Day register bits [5:4] hold date tens
// R11: Compare each second; match sets the flag
// R12: Flag and enable drive interrupt until cleared
// R13: Writing one clears flag; zero leaves it
// R14: All masks clear: day, hour, min, sec
// R15: Set mask bit drops its field from compare
// R16: All alarm register fields reset to zero
`include "rtc_alarm_consts.vh"

module rtc_dual_alarm_match #(
    parameter NUM_ALARMS = 2                 // Independent alarms
) (
    input  wire       sys_clk,                // 125 MHz system clock
    input  wire       resetn,                 // Async reset, active low
    input  wire       reg_wr,                 // Register write strobe
    input  wire       reg_rd,                 // Register read strobe
    input  wire [7:0] reg_addr,               // Register offset
    input  wire [7:0] reg_wdata,              // Write data
    output wire [7:0] reg_rdata,              // Read data, registered
    input  wire       sec_tick,               // One pulse per second
    input  wire [7:0] time_sec,               // Current seconds, BCD
    input  wire [7:0] time_min,               // Current minutes, BCD
    input  wire [7:0] time_hr,                // Current hours, BCD
    input  wire [7:0] time_day,               // Current weekday, BCD
    input  wire [7:0] time_date,              // Current date, BCD
    input  wire       alarm1_irq_enable,      // Alarm 1 interrupt enable
    input  wire       alarm2_irq_enable,      // Alarm 2 interrupt enable
    input  wire       flag_clr_wr,            // Status write strobe
    input  wire [1:0] flag_clr_data,          // One bit per flag, 1 clears
    output wire       alarm1_match_flag,      // Alarm 1 matched
    output wire       alarm2_match_flag,      // Alarm 2 matched
    output wire       alarm_irq               // Interrupt, active high
);

    localparam ALARM2_BASE = 4;               // First storage index of alarm 2

    reg                   rst_sync1_ff;
    reg                   rst_sync2_ff;
    wire                  rst_n;
    reg  [7:0]            alarm_regs_ff [0:4*NUM_ALARMS-1];
    reg  [7:0]            rdata_ff;
    reg  [7:0]            nxt_rdata;
    reg  [NUM_ALARMS-1:0] flag_ff;
    wire [NUM_ALARMS-1:0] match;
    wire [NUM_ALARMS-1:0] irq_en;
    wire [NUM_ALARMS-1:0] clr_req;
    wire                  addr_hit;
    wire [7:0]            addr_ofs;
    wire [2:0]            reg_idx;
    // Named field views of the value registers
    wire [3:0]            alarm1_sec_units;
    wire [2:0]            alarm1_sec_tens;
    wire                  alarm1_mask_sec;
    wire [3:0]            alarm2_sec_units;
    wire [2:0]            alarm2_sec_tens;
    wire                  alarm2_mask_sec;
    wire [3:0]            alarm1_min_units;
    wire [2:0]            alarm1_min_tens;
    wire                  alarm1_mask_min;
    wire [3:0]            alarm2_min_units;
    wire [2:0]            alarm2_min_tens;
    wire                  alarm2_mask_min;
    wire [3:0]            alarm1_hr_units;
    wire                  alarm1_hr_tens_lsb;
    wire                  alarm1_afternoon_or_tens_msb;
    wire                  alarm1_twelve_hour_sel;
    wire                  alarm1_mask_hr;
    wire [3:0]            alarm2_hr_units;
    wire                  alarm2_hr_tens_lsb;
    wire                  alarm2_afternoon_or_tens_msb;
    wire                  alarm2_twelve_hour_sel;
    wire                  alarm2_mask_hr;
    wire [3:0]            alarm1_weekday_or_date_units;
    wire [1:0]            alarm1_date_tens;
    wire                  alarm1_weekday_sel;
    wire                  alarm1_mask_daydate;
    wire [3:0]            alarm2_weekday_or_date_units;
    wire [1:0]            alarm2_date_tens;
    wire                  alarm2_weekday_sel;
    wire                  alarm2_mask_daydate;
    wire [7:0]            cmp_sec [0:NUM_ALARMS-1];
    wire [7:0]            cmp_min [0:NUM_ALARMS-1];
    wire [7:0]            cmp_hr  [0:NUM_ALARMS-1];
    wire [7:0]            cmp_day [0:NUM_ALARMS-1];

    // Reset release through two flops; assertion stays asynchronous
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync1_ff <= 1'b0;
            rst_sync2_ff <= 1'b0;
        end else begin
            rst_sync1_ff <= 1'b1;
            rst_sync2_ff <= rst_sync1_ff;
        end
    end
    assign rst_n = rst_sync2_ff;

    // Address decode onto the eight value registers
    assign addr_hit = (reg_addr >= `ALARM_FIRST_OFS) &&
                      (reg_addr <= `ALARM_LAST_OFS);
    assign addr_ofs = reg_addr - `ALARM_FIRST_OFS;
    assign reg_idx  = addr_ofs[2:0];

    // Value register storage, written whole; all bits plain read/write
    genvar gi;
    generate
        for (gi = 0; gi < 4*NUM_ALARMS; gi = gi + 1) begin : g_reg
            always @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    alarm_regs_ff[gi] <= `ALARM_REG_RESET;   // R16
                end else if (reg_wr && addr_hit &&
                             (reg_idx == gi)) begin
                    alarm_regs_ff[gi] <= reg_wdata;          // R01
                end
            end
        end
    endgenerate

    // Read mux; offsets outside the alarm group read as zero
    always @* begin
        if (addr_hit) begin
            nxt_rdata = alarm_regs_ff[reg_idx];              // R01
        end else begin
            nxt_rdata = 8'h00;
        end
    end

    // Read data held until the next read strobe
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= `RDATA_RESET;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign reg_rdata = rdata_ff;

    // Seconds fields; field positions are stated once, here
    assign alarm1_sec_units = // R02
        alarm_regs_ff[`IDX_SEC][`UNITS_MSB:`UNITS_LSB];
    assign alarm1_sec_tens = // R02
        alarm_regs_ff[`IDX_SEC][`TENS_MSB:`TENS_LSB];
    assign alarm1_mask_sec = // R02 R15
        alarm_regs_ff[`IDX_SEC][`MASK_BIT];
    assign alarm2_sec_units = // R02
        alarm_regs_ff[ALARM2_BASE+`IDX_SEC][`UNITS_MSB:`UNITS_LSB];
    assign alarm2_sec_tens = // R02
        alarm_regs_ff[ALARM2_BASE+`IDX_SEC][`TENS_MSB:`TENS_LSB];
    assign alarm2_mask_sec = // R02 R15
        alarm_regs_ff[ALARM2_BASE+`IDX_SEC][`MASK_BIT];

    // Minutes fields
    assign alarm1_min_units = // R03
        alarm_regs_ff[`IDX_MIN][`UNITS_MSB:`UNITS_LSB];
    assign alarm1_min_tens = // R03
        alarm_regs_ff[`IDX_MIN][`TENS_MSB:`TENS_LSB];
    assign alarm1_mask_min = // R03 R15
        alarm_regs_ff[`IDX_MIN][`MASK_BIT];
    assign alarm2_min_units = // R03
        alarm_regs_ff[ALARM2_BASE+`IDX_MIN][`UNITS_MSB:`UNITS_LSB];
    assign alarm2_min_tens = // R03
        alarm_regs_ff[ALARM2_BASE+`IDX_MIN][`TENS_MSB:`TENS_LSB];
    assign alarm2_mask_min = // R03 R15
        alarm_regs_ff[ALARM2_BASE+`IDX_MIN][`MASK_BIT];

    // Hours fields; bit 5 means afternoon or tens msb by format
    assign alarm1_hr_units = // R04
        alarm_regs_ff[`IDX_HR][`UNITS_MSB:`UNITS_LSB];
    assign alarm1_hr_tens_lsb = // R04
        alarm_regs_ff[`IDX_HR][`HR_TENS_LSB_BIT];
    assign alarm1_afternoon_or_tens_msb = // R06
        alarm_regs_ff[`IDX_HR][`HR_AFTERNOON_BIT];
    assign alarm1_twelve_hour_sel = // R05
        alarm_regs_ff[`IDX_HR][`HR_TWELVE_SEL_BIT];
    assign alarm1_mask_hr = // R04 R15
        alarm_regs_ff[`IDX_HR][`MASK_BIT];
    assign alarm2_hr_units = // R04
        alarm_regs_ff[ALARM2_BASE+`IDX_HR][`UNITS_MSB:`UNITS_LSB];
    assign alarm2_hr_tens_lsb = // R04
        alarm_regs_ff[ALARM2_BASE+`IDX_HR][`HR_TENS_LSB_BIT];
    assign alarm2_afternoon_or_tens_msb = // R06
        alarm_regs_ff[ALARM2_BASE+`IDX_HR][`HR_AFTERNOON_BIT];
    assign alarm2_twelve_hour_sel = // R05
        alarm_regs_ff[ALARM2_BASE+`IDX_HR][`HR_TWELVE_SEL_BIT];
    assign alarm2_mask_hr = // R04 R15
        alarm_regs_ff[ALARM2_BASE+`IDX_HR][`MASK_BIT];

    // Day-or-date fields; the low nibble's meaning follows bit 6
    assign alarm1_weekday_or_date_units = // R08 R09
        alarm_regs_ff[`IDX_DAY][`UNITS_MSB:`UNITS_LSB];
    assign alarm1_date_tens = // R10
        alarm_regs_ff[`IDX_DAY][`DATE_TENS_MSB:`DATE_TENS_LSB];
    assign alarm1_weekday_sel = // R07
        alarm_regs_ff[`IDX_DAY][`WEEKDAY_SEL_BIT];
    assign alarm1_mask_daydate = // R07 R15
        alarm_regs_ff[`IDX_DAY][`MASK_BIT];
    assign alarm2_weekday_or_date_units = // R08 R09
        alarm_regs_ff[ALARM2_BASE+`IDX_DAY][`UNITS_MSB:`UNITS_LSB];
    assign alarm2_date_tens = // R10
        alarm_regs_ff[ALARM2_BASE+`IDX_DAY][`DATE_TENS_MSB:`DATE_TENS_LSB];
    assign alarm2_weekday_sel = // R07
        alarm_regs_ff[ALARM2_BASE+`IDX_DAY][`WEEKDAY_SEL_BIT];
    assign alarm2_mask_daydate = // R07 R15
        alarm_regs_ff[ALARM2_BASE+`IDX_DAY][`MASK_BIT];

    // Compare words rebuilt from the fields, one set per alarm
    assign cmp_sec[0] = {alarm1_mask_sec, alarm1_sec_tens, alarm1_sec_units};
    assign cmp_min[0] = {alarm1_mask_min, alarm1_min_tens, alarm1_min_units};
    assign cmp_hr[0]  = {alarm1_mask_hr, alarm1_twelve_hour_sel,
                         alarm1_afternoon_or_tens_msb,
                         alarm1_hr_tens_lsb, alarm1_hr_units};
    assign cmp_day[0] = {alarm1_mask_daydate, alarm1_weekday_sel,
                         alarm1_date_tens, alarm1_weekday_or_date_units};
    assign cmp_sec[1] = {alarm2_mask_sec, alarm2_sec_tens, alarm2_sec_units};
    assign cmp_min[1] = {alarm2_mask_min, alarm2_min_tens, alarm2_min_units};
    assign cmp_hr[1]  = {alarm2_mask_hr, alarm2_twelve_hour_sel,
                         alarm2_afternoon_or_tens_msb,
                         alarm2_hr_tens_lsb, alarm2_hr_units};
    assign cmp_day[1] = {alarm2_mask_daydate, alarm2_weekday_sel,
                         alarm2_date_tens, alarm2_weekday_or_date_units};

    // Enables and clear bits, bit i belongs to alarm i+1
    assign irq_en  = {alarm2_irq_enable, alarm1_irq_enable};
    assign clr_req = {NUM_ALARMS{flag_clr_wr}} & flag_clr_data;

    // One comparator and one sticky flag per alarm
    generate
        for (gi = 0; gi < NUM_ALARMS; gi = gi + 1) begin : g_alarm
            alarm_compare u_cmp (
                .alm_sec   (cmp_sec[gi]),
                .alm_min   (cmp_min[gi]),
                .alm_hr    (cmp_hr[gi]),
                .alm_day   (cmp_day[gi]),
                .time_sec  (time_sec),
                .time_min  (time_min),
                .time_hr   (time_hr),
                .time_day  (time_day),
                .time_date (time_date),
                .match     (match[gi])
            );

            // Set wins over a clear in the same cycle, so no match is lost
            always @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    flag_ff[gi] <= `FLAG_RESET;
                end else if (sec_tick && match[gi]) begin
                    flag_ff[gi] <= 1'b1;                     // R11
                end else if (clr_req[gi]) begin
                    flag_ff[gi] <= 1'b0;                     // R13
                end
            end
        end
    endgenerate

    // Flags leave straight from their flops
    assign alarm1_match_flag = flag_ff[0];
    assign alarm2_match_flag = flag_ff[1];

    // Interrupt is a level that follows flags, so it holds until cleared
    assign alarm_irq = |(flag_ff & irq_en);                  // R12

endmodule // rtc_dual_alarm_match

// file: include/rtc_alarm_consts.vh
// Register offsets, field positions and reset values for the alarm block
`ifndef RTC_ALARM_CONSTS_VH
`define RTC_ALARM_CONSTS_VH

// Register offsets on the register port
`define ALARM1_SECONDS_OFS     8'h47
`define ALARM1_MINUTES_OFS     8'h48
`define ALARM1_HOURS_OFS       8'h49
`define ALARM1_DAY_OR_DATE_OFS 8'h4A
`define ALARM2_SECONDS_OFS     8'h4B
`define ALARM2_MINUTES_OFS     8'h4C
`define ALARM2_HOURS_OFS       8'h4D
`define ALARM2_DAY_OR_DATE_OFS 8'h4E
`define ALARM_FIRST_OFS        8'h47
`define ALARM_LAST_OFS         8'h4E

// Register index within one alarm's group of four
`define IDX_SEC                2'h0
`define IDX_MIN                2'h1
`define IDX_HR                 2'h2
`define IDX_DAY                2'h3

// Field positions
`define MASK_BIT               7
`define UNITS_MSB              3
`define UNITS_LSB              0
`define TENS_MSB               6
`define TENS_LSB               4
`define HR_TENS_LSB_BIT        4
`define HR_AFTERNOON_BIT       5
`define HR_TWELVE_SEL_BIT      6
`define DATE_TENS_MSB          5
`define DATE_TENS_LSB          4
`define WEEKDAY_SEL_BIT        6

// Reset values
`define ALARM_REG_RESET        8'h00
`define FLAG_RESET             1'h0
`define RDATA_RESET            8'h00

`endif
